// >>> dv/mfp_pin_config_props.sv
// checker for the multifunction pin configuration block
`timescale 1ns/10ps
module mfp_pin_config_props (
   input wire logic                  clk,
   input wire logic                  reset,
   input wire logic                  regRead,
   input wire logic [7:0]            regPage,
   input wire logic [7:0]            regAddr,
   input wire logic [7:0]            regRdata,
   input wire logic [3:0]            bidirSelect,
   input wire logic [3:0]            outPinOneSelect,
   input wire mfp_pkg::mfp_sources_t sources,
   input wire logic                  bidirPinOut,
   input wire logic                  bidirPinOe,
   input wire logic                  outPinOne,
   input wire logic                  outPinOneOe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // a read of page 0; the assertions check its answer one edge later
   sequence s_read(logic [7:0] a);
      regRead && regPage == 8'h00 && regAddr == a;
   endsequence
   // a function held with steady sources, long enough for the output flops
   sequence s_bidir(logic [3:0] c);
      (bidirSelect == c && $stable(sources)) [*3];
   endsequence
   a_bidir_irq: assert property (s_bidir(4'h2) |-> bidirPinOe && bidirPinOut == sources.irq)
      else $error("bidir pin not carrying irq");
   a_bidir_clock: assert property (s_bidir(4'h4) |-> bidirPinOe && bidirPinOut == sources.micClock)
      else $error("bidir pin not carrying mic clock");
   a_bidir_input: assert property (s_bidir(4'h9) |-> !bidirPinOe)
      else $error("bidir pin driven while input");
   a_bidir_reserved: assert property ((bidirSelect inside {[4'h5:4'h8], [4'hA:4'hF]}) [*3]
      |-> !bidirPinOe) else $error("bidir pin driven on reserved code");
   a_one_reserved: assert property ((outPinOneSelect > 4'h4) [*3] |-> !outPinOneOe && !outPinOne)
      else $error("out pin one driven on reserved code");
   a_unmapped_zero: assert property (regRead && regPage != 8'h00 |=> regRdata == 8'h00)
      else $error("unmapped page read not zero");
   a_monitor_low: assert property (s_read(8'h2A) |=> regRdata[6:0] == 7'h00)
      else $error("monitor low bits not zero");
   a_levels_low: assert property (s_read(8'h29) |=> regRdata[2:0] == 3'h0)
      else $error("level register low bits not zero");
   a_rdata_holds: assert property (!regRead |=> $stable(regRdata))
      else $error("read data changed without a read");
endmodule
bind mfp_pin_config mfp_pin_config_props mfp_pin_config_props_i (.clk, .reset, .regRead,
   .regPage, .regAddr, .regRdata, .bidirSelect, .outPinOneSelect, .sources, .bidirPinOut,
   .bidirPinOe, .outPinOne, .outPinOneOe);

// >>> dv/mfp_pin_config_test.sv
// self-checking bench for the multifunction pin configuration block
`timescale 1ns/10ps
module mfp_pin_config_test;
   typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] want;} mfp_row_t;
   localparam mfp_row_t ROWS [7] = '{'{8'h23, 8'hFF, 8'hF0}, '{8'h24, 8'hA5, 8'hA0},
      '{8'h25, 8'h3C, 8'h30}, '{8'h29, 8'hFF, 8'hF8}, '{8'h2B, 8'hFF, 8'h77},
      '{8'h2A, 8'hFF, 8'h00}, '{8'h26, 8'h5A, 8'h00}};
   logic       clk = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0;
   logic       hostOe = 1'b0, hostLevel = 1'b0, bidirPinOut, bidirPinOe, outPinOne;
   logic       outPinOneOe, pinWire, masterClockIn, daisyChainSerialIn;
   logic [7:0] regPage = 8'h00, regAddr = 8'h00, regWdata = 8'h00, regRdata, rd, e;
   logic [3:0] bidirSelect = 4'h0, outPinOneSelect = 4'h0, micDataPair;
   logic [2:0] outPinTwoToFour, outPinTwoToFourOe;
   logic [1:0] inPins = 2'h0, inPinGeneral, ox;
   int         err_total = 0, comparisons = 0, cycles = 0;
   mfp_pkg::mfp_sources_t sources = '0;
   wire logic [9:0] pinState = {bidirPinOe, bidirPinOut, outPinOneOe, outPinOne,
                                outPinTwoToFourOe, outPinTwoToFour};
   wire logic [7:0] inState  = {inPinGeneral, masterClockIn, daisyChainSerialIn, micDataPair};
   mfp_pin_config mfp_pin_config_i (.clk, .reset, .regWrite, .regRead, .regPage, .regAddr,
      .regWdata, .regRdata, .bidirSelect, .outPinOneSelect, .sources, .bidirPinIn(pinWire),
      .bidirPinOut, .bidirPinOe, .outPinOne, .outPinOneOe, .outPinTwoToFour,
      .outPinTwoToFourOe, .inPins, .inPinGeneral, .masterClockIn, .daisyChainSerialIn,
      .micDataPair);
   mfp_pin_model mfp_pin_model_i (.clk, .drvOut(bidirPinOut), .drvOe(bidirPinOe),
      .hostOe, .hostLevel, .pinLevel(pinWire));
   initial forever #12.5 clk = ~clk;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) {regWrite, regAddr, regWdata} <= {1'b1, a, d};
      @(posedge clk) regWrite <= 1'b0;
   endtask
   task automatic rdReg(input logic [7:0] a);
      @(posedge clk) {regRead, regAddr} <= {1'b1, a};
      @(posedge clk) regRead <= 1'b0;
      #1 rd = regRdata;
   endtask
   task automatic setOut(input logic [3:0] c);
      for (int k = 0; k < 3; k++) wr(8'(8'h23 + k), {c, 4'h0});
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic chkReg(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chkPin(input logic [9:0] got, input logic [9:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // {enable, level} of a pin for one function code, with only source p high
   function automatic logic [1:0] expPin(int c, int p);
      case (c)
         1: return 2'h3;
         2, 3, 4: return {1'b1, p == c - 2};
         default: return 2'h0;
      endcase
   endfunction
   function automatic logic [7:0] expIn(int c, int p);
      logic [7:0] r;
      int         k;
      r = 8'h00;
      for (int i = 0; i < 2; i++) begin
         k = i ? 7 - c : c;
         if (k == 1) r[6 + i] = (i == p);
         if (k == 2) r[5] = r[5] | (i == p);
         if (k == 3) r[4] = r[4] | (i == p);
         if (k >= 4) r[k - 4] = r[k - 4] | (i == p);
      end
      return r;
   endfunction
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ceiling well above the roughly 700 cycles the sequence needs
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         err_total++;
         final_report();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      foreach (ROWS[i]) begin
         wr(ROWS[i].addr, ROWS[i].wdata);
         rdReg(ROWS[i].addr);
         chkReg(rd, ROWS[i].want);
      end
      $display("test register rows done");
      @(posedge clk) reset <= 1'b1;
      repeat (3) @(posedge clk) reset <= 1'b0;
      foreach (ROWS[i]) begin
         rdReg(ROWS[i].addr);
         chkReg(rd, 8'h00);
      end
      chkPin(pinState, 10'h000);
      // a write on another page must not reach page 0, and its read gives zero
      @(posedge clk) regPage <= 8'h01;
      wr(8'h23, 8'h40);
      rdReg(8'h23);
      chkReg(rd, 8'h00);
      @(posedge clk) regPage <= 8'h00;
      rdReg(8'h23);
      chkReg(rd, 8'h00);
      $display("test second reset done");
      wr(8'h29, 8'hF8);
      for (int p = 0; p < 3; p++) for (int c = 0; c < 16; c++) begin
         @(posedge clk) {sources, bidirSelect, outPinOneSelect} <= {3'h4 >> p, c[3:0], c[3:0]};
         setOut(c[3:0]);
         ox = expPin(c, p);
         chkPin(pinState, {ox, ox, {3{ox[1]}}, {3{ox[0]}}});
      end
      $display("test function codes done");
      for (int v = 0; v < 2; v++) begin
         e = v ? 8'h50 : 8'hA8;
         @(posedge clk) {bidirSelect, outPinOneSelect} <= 8'h11;
         wr(8'h29, e);
         setOut(4'h1);
         chkPin(pinState, {1'b1, e[7], 1'b1, e[6], 3'h7, e[3], e[4], e[5]});
      end
      $display("test output levels done");
      for (int v = 0; v < 3; v++) begin
         @(posedge clk) {bidirSelect, hostOe, hostLevel} <= {v == 2 ? 4'h0 : 4'h9, 1'b1, v != 1};
         repeat (4) @(posedge clk);
         rdReg(8'h2A);
         chkReg(rd, v == 0 ? 8'h80 : 8'h00);
      end
      @(posedge clk) hostOe <= 1'b0;
      $display("test bidir monitor done");
      for (int p = 0; p < 2; p++) for (int c = 0; c < 8; c++) begin
         @(posedge clk) inPins <= p ? 2'h2 : 2'h1;
         wr(8'h2B, {1'b0, c[2:0], 1'b0, 3'(7 - c)});
         repeat (3) @(posedge clk);
         #1 chkReg(inState, expIn(c, p));
      end
      $display("test input routing done");
      final_report();
   end
endmodule

// >>> dv/mfp_pin_model.sv
// model of the board wire on the bidir pin, shared by device and host
`timescale 1ns/10ps
module mfp_pin_model (
   input wire logic clk,
   input wire logic drvOut,
   input wire logic drvOe,
   input wire logic hostOe,
   input wire logic hostLevel,
   output logic     pinLevel
);
   // no pull on this wire: a floating pin toggles so a stale level never reads back
   logic floatLevel = 1'b0;
   // an unknown level at start-up counts as low, so the wire never stays unknown
   always @(posedge clk) floatLevel <= (pinLevel !== 1'b1);
   assign pinLevel = drvOe ? drvOut : (hostOe ? hostLevel : floatLevel);
endmodule

// >>> rtl/mfp_pin_config.sv
// multifunction pin function select, output levels and input monitor
`timescale 1ns/10ps
module mfp_pin_config (
   input  wire logic                  clk,
   input  wire logic                  reset,
   input  wire logic                  regWrite,
   input  wire logic                  regRead,
   input  wire logic [7:0]            regPage,
   input  wire logic [7:0]            regAddr,
   input  wire logic [7:0]            regWdata,
   output logic      [7:0]            regRdata,
   input  wire logic [3:0]            bidirSelect,
   input  wire logic [3:0]            outPinOneSelect,
   input  wire mfp_pkg::mfp_sources_t sources,
   input  wire logic                  bidirPinIn,
   output logic                       bidirPinOut,
   output logic                       bidirPinOe,
   output logic                       outPinOne,
   output logic                       outPinOneOe,
   output logic      [2:0]            outPinTwoToFour,
   output logic      [2:0]            outPinTwoToFourOe,
   input  wire logic [1:0]            inPins,
   output logic      [1:0]            inPinGeneral,
   output logic                       masterClockIn,
   output logic                       daisyChainSerialIn,
   output logic      [3:0]            micDataPair
);
   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   logic [3:0] outSelect_q [3];
   logic [3:0] outSelect_d [3];
   logic [7:0] levels_q, levels_d;
   logic [7:0] inSelect_q, inSelect_d;
   logic [7:0] rdata_q, rdata_d;
   logic       syncA_q, syncB_q, monitor_q, monitor_d;
   logic       onPage;

   assign onPage = (regPage == mfp_pkg::PAGE_CFG);

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         outSelect_d[i] = outSelect_q[i];
      end
      levels_d   = levels_q;
      inSelect_d = inSelect_q;
      if (regWrite && onPage) begin
         unique case (regAddr)
            mfp_pkg::OFS_OUT_TWO:    outSelect_d[0] = regWdata[mfp_pkg::SEL_HI:mfp_pkg::SEL_LO];
            mfp_pkg::OFS_OUT_THREE:  outSelect_d[1] = regWdata[mfp_pkg::SEL_HI:mfp_pkg::SEL_LO];
            mfp_pkg::OFS_OUT_FOUR:   outSelect_d[2] = regWdata[mfp_pkg::SEL_HI:mfp_pkg::SEL_LO];
            mfp_pkg::OFS_LEVELS:     levels_d   = regWdata & mfp_pkg::LEVELS_MASK;
            mfp_pkg::OFS_IN_ONE_TWO: inSelect_d = regWdata & mfp_pkg::IN_MASK;
            default: ;
         endcase
      end
   end

   // read data; reserved bits and unmapped offsets read zero
   always_comb begin
      rdata_d = rdata_q;
      if (regRead) begin
         rdata_d = mfp_pkg::READ_UNMAPPED;
         if (onPage) begin
            unique case (regAddr)
               mfp_pkg::OFS_OUT_TWO:    rdata_d = {outSelect_q[0], 4'h0};
               mfp_pkg::OFS_OUT_THREE:  rdata_d = {outSelect_q[1], 4'h0};
               mfp_pkg::OFS_OUT_FOUR:   rdata_d = {outSelect_q[2], 4'h0};
               mfp_pkg::OFS_LEVELS:     rdata_d = levels_q;
               mfp_pkg::OFS_MONITOR:    rdata_d = {monitor_q, 7'h00};
               mfp_pkg::OFS_IN_ONE_TWO: rdata_d = inSelect_q;
               default:                 rdata_d = mfp_pkg::READ_UNMAPPED;
            endcase
         end
      end
   end

   // monitor reads the second synchroniser flop only while the bidir pin is an input
   assign monitor_d = (bidirSelect == mfp_pkg::FN_BIDIR_IN) ? syncB_q : 1'b0;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < 3; i++) begin
            outSelect_q[i] <= 4'h0;
         end
         levels_q   <= mfp_pkg::RESET_VALUE;
         inSelect_q <= mfp_pkg::RESET_VALUE;
         rdata_q    <= mfp_pkg::RESET_VALUE;
         syncA_q    <= 1'b0;
         syncB_q    <= 1'b0;
         monitor_q  <= 1'b0;
      end else begin
         outSelect_q <= outSelect_d;
         levels_q    <= levels_d;
         inSelect_q  <= inSelect_d;
         rdata_q     <= rdata_d;
         syncA_q     <= bidirPinIn;
         syncB_q     <= syncA_q;
         monitor_q   <= monitor_d;
      end
   end

   assign regRdata = rdata_q;

   // ----------------------------------------------------------------
   // output pin drivers
   // ----------------------------------------------------------------
   // reserved codes fall to the disabled case so a stray write cannot glitch a pin
   function automatic mfp_pkg::mfp_drive_t pinDrive(input logic [3:0] sel,
                                                    input logic       level,
                                                    input mfp_pkg::mfp_sources_t src);
      mfp_pkg::mfp_drive_t drv;
      drv = '{level: 1'b0, enable: 1'b0};
      case (sel)
         mfp_pkg::FN_LEVEL:  drv = '{level: level,         enable: 1'b1};
         mfp_pkg::FN_IRQ:    drv = '{level: src.irq,       enable: 1'b1};
         mfp_pkg::FN_SERIAL: drv = '{level: src.serialOut, enable: 1'b1};
         mfp_pkg::FN_MICCLK: drv = '{level: src.micClock,  enable: 1'b1};
         default:            drv = '{level: 1'b0,          enable: 1'b0};
      endcase
      return drv;
   endfunction

   mfp_pkg::mfp_drive_t bidir_d, bidir_q, one_d, one_q;
   mfp_pkg::mfp_drive_t pins_d [3];
   mfp_pkg::mfp_drive_t pins_q [3];

   always_comb begin
      bidir_d = pinDrive(bidirSelect, levels_q[mfp_pkg::LVL_BIDIR], sources);
      one_d   = pinDrive(outPinOneSelect, levels_q[mfp_pkg::LVL_OUT_ONE], sources);
      for (int i = 0; i < 3; i++) begin
         pins_d[i] = pinDrive(outSelect_q[i], levels_q[mfp_pkg::LVL_OUT_TWO - i], sources);
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bidir_q <= '{level: 1'b0, enable: 1'b0};
         one_q   <= '{level: 1'b0, enable: 1'b0};
         for (int i = 0; i < 3; i++) begin
            pins_q[i] <= '{level: 1'b0, enable: 1'b0};
         end
      end else begin
         bidir_q <= bidir_d;
         one_q   <= one_d;
         pins_q  <= pins_d;
      end
   end

   assign bidirPinOut = bidir_q.level;
   assign bidirPinOe  = bidir_q.enable;
   assign outPinOne   = one_q.level;
   assign outPinOneOe = one_q.enable;

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : gOut
         assign outPinTwoToFour[g]   = pins_q[g].level;
         assign outPinTwoToFourOe[g] = pins_q[g].enable;
      end
   endgenerate

   // ----------------------------------------------------------------
   // input pin routing
   // ----------------------------------------------------------------
   logic [2:0] inSel [2];
   logic [1:0] gen_d, gen_q, mclk_d, mclk_q, daisy_d, daisy_q;
   logic [3:0] mic_d [2];
   logic [3:0] mic_q [2];

   assign inSel[0] = inSelect_q[mfp_pkg::IN_ONE_HI:mfp_pkg::IN_ONE_LO];
   assign inSel[1] = inSelect_q[mfp_pkg::IN_TWO_HI:mfp_pkg::IN_TWO_LO];

   generate
      for (g = 0; g < 2; g++) begin : gIn
         assign gen_d[g]   = (inSel[g] == mfp_pkg::IN_GENERAL) & inPins[g];
         assign mclk_d[g]  = (inSel[g] == mfp_pkg::IN_MCLK) & inPins[g];
         assign daisy_d[g] = (inSel[g] == mfp_pkg::IN_DAISY) & inPins[g];
         always_comb begin
            mic_d[g] = 4'h0;
            if (inSel[g] >= mfp_pkg::IN_MIC_BASE) begin
               mic_d[g][inSel[g][1:0]] = inPins[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         gen_q    <= 2'h0;
         mclk_q   <= 2'h0;
         daisy_q  <= 2'h0;
         mic_q[0] <= 4'h0;
         mic_q[1] <= 4'h0;
      end else begin
         gen_q   <= gen_d;
         mclk_q  <= mclk_d;
         daisy_q <= daisy_d;
         mic_q   <= mic_d;
      end
   end

   assign inPinGeneral       = gen_q;
   assign masterClockIn      = |mclk_q;
   assign daisyChainSerialIn = |daisy_q;
   assign micDataPair        = mic_q[0] | mic_q[1];
endmodule

// >>> rtl/mfp_pkg.sv
// constants and types for the multifunction pin configuration block
//
// Overview of operation
// - out pin two function comes from bits 7-4: 0 off,1 level,2 irq,3 serial,4 clock
// - out pin three uses the same 4-bit selector and codes in its own register
// - out pin four uses the same selector; its low four bits read zero
// - function registers at page 0 offsets 23h-25h reset to zero, pins disabled
// - bidir pin as general output drives output-level bit 7
// - out pin one as general output drives output-level bit 6
// - out pins two to four drive level bits 5,4,3; bits 2-0 read zero
// - bidir pin as general input shows its level in monitor bit 7 at 2Ah
// - input function register at 2Bh resets zero; selectors in bits 6-4 and 2-0
// - input codes: 0 off,1 input,2 master clock,3 daisy serial,4-7 mic pairs
package mfp_pkg;
   // ----------------------------------------------------------------
   // register map, page 0
   // ----------------------------------------------------------------
   localparam logic [7:0] PAGE_CFG        = 8'h00;
   localparam logic [7:0] OFS_OUT_TWO     = 8'h23;
   localparam logic [7:0] OFS_OUT_THREE   = 8'h24;
   localparam logic [7:0] OFS_OUT_FOUR    = 8'h25;
   localparam logic [7:0] OFS_LEVELS      = 8'h29;
   localparam logic [7:0] OFS_MONITOR     = 8'h2A;
   localparam logic [7:0] OFS_IN_ONE_TWO  = 8'h2B;
   localparam logic [7:0] RESET_VALUE     = 8'h00;
   localparam logic [7:0] READ_UNMAPPED   = 8'h00;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int SEL_HI          = 7;
   localparam int SEL_LO          = 4;
   localparam int LVL_BIDIR       = 7;
   localparam int LVL_OUT_ONE     = 6;
   localparam int LVL_OUT_TWO     = 5;
   localparam int MON_BIT         = 7;
   localparam int IN_ONE_HI       = 6;
   localparam int IN_ONE_LO       = 4;
   localparam int IN_TWO_HI       = 2;
   localparam int IN_TWO_LO       = 0;
   localparam logic [7:0] LEVELS_MASK = 8'hF8;
   localparam logic [7:0] SEL_MASK    = 8'hF0;
   localparam logic [7:0] IN_MASK     = 8'h77;
   // ----------------------------------------------------------------
   // function codes
   // ----------------------------------------------------------------
   localparam logic [3:0] FN_OFF      = 4'h0;
   localparam logic [3:0] FN_LEVEL    = 4'h1;
   localparam logic [3:0] FN_IRQ      = 4'h2;
   localparam logic [3:0] FN_SERIAL   = 4'h3;
   localparam logic [3:0] FN_MICCLK   = 4'h4;
   localparam logic [3:0] FN_BIDIR_IN = 4'h9;
   localparam logic [2:0] IN_OFF      = 3'h0;
   localparam logic [2:0] IN_GENERAL  = 3'h1;
   localparam logic [2:0] IN_MCLK     = 3'h2;
   localparam logic [2:0] IN_DAISY    = 3'h3;
   localparam logic [2:0] IN_MIC_BASE = 3'h4;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic level;
      logic enable;
   } mfp_drive_t;
   typedef struct packed {
      logic irq;
      logic serialOut;
      logic micClock;
   } mfp_sources_t;
endpackage
